// *** include/acs_map.vh ***
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// Frame and register geometry.
`define ACS_WORD_W 22
`define ACS_CNT_W 5
`define ACS_WORD_BITS 5'h16

// Register offsets.
`define ACS_OFS_PWR 8'h04
`define ACS_OFS_WPROT 8'h08
`define ACS_OFS_RPROT 8'h0c
`define ACS_OFS_OWORD 8'h10
`define ACS_OFS_PAT_LO 8'h14
`define ACS_OFS_PAT_MID 8'h15
`define ACS_OFS_PAT_HI 8'h16
`define ACS_OFS_OFSCAL 8'h20
`define ACS_OFS_REFMRG 8'h30

// Writable bit masks; masked bits read as zero.
`define ACS_MSK_PWR 8'h06
`define ACS_MSK_WPROT 8'h03
`define ACS_MSK_RPROT 8'hdf
`define ACS_MSK_OWORD 8'h0f
`define ACS_MSK_PAT_HI 8'h0f
`define ACS_MSK_FULL 8'hff

// Field positions.
`define ACS_BIT_REFBUF_OFF 2
`define ACS_BIT_CORE_OFF 1
`define ACS_BIT_CPOL 1
`define ACS_BIT_CPHA 0

// Reset values.
`define ACS_RST_REG 8'h00
`define ACS_RST_WORD 22'h000000

// Legacy read protocol values.
`define ACS_RPROT_LEGACY0 8'h00
`define ACS_RPROT_LEGACY1 8'h01

// Command word layout: opcode, address, data.
`define ACS_CMD_OP_HI 21
`define ACS_CMD_OP_LO 18
`define ACS_CMD_ADDR_HI 15
`define ACS_CMD_ADDR_LO 8
`define ACS_OP_WRITE 4'h1
`define ACS_OP_READ 4'h2

`endif

// *** verilog/acs_spi_chain.v ***
`timescale 1ns/1ps
`include "acs_map.vh"

module acs_spi_chain (
    input wire sys_clk_i,                          // System clock, 40 MHz.
    input wire rst_n_i,                            // Asynchronous reset, active low.
    input wire conv_start_i,                       // Conversion start pin.
    input wire cs_n_i,                             // Chip select pin, active low.
    input wire sclk_i,                             // Serial clock pin.
    input wire sdi_i,                              // Serial data in pin.
    input wire conv_done_i,                        // Core result valid pulse.
    input wire [`ACS_WORD_W-1:0] conv_data_i,      // Core conversion result.
    output reg sdo_o,                              // Serial data out, line 0.
    output reg sdo_oe_o,                           // High while the device drives the data line.
    output reg sample_o,                           // One-cycle pulse: analog input sampled.
    output reg core_off_o,                         // Converter core powered down.
    output reg ref_buf_off_o,                      // Reference buffer powered down.
    output reg unified_o,                          // Unified shift register in use.
    output reg [19:0] test_pattern_o               // Assembled output test pattern.
);

    // Pin synchronisers and edge history.
    reg conv_s1_r;
    reg conv_s2_r;
    reg conv_s3_r;
    reg cs_s1_r;
    reg cs_s2_r;
    reg cs_s3_r;
    reg sclk_s1_r;
    reg sclk_s2_r;
    reg sclk_s3_r;
    reg sdi_s1_r;
    reg sdi_s2_r;

    // Configuration registers.
    reg [7:0] power_down_control_r;
    reg [7:0] write_protocol_select_r;
    reg [7:0] read_protocol_select_r;
    reg [7:0] output_word_config_r;
    reg [7:0] test_pattern_low_r;
    reg [7:0] test_pattern_mid_r;
    reg [7:0] test_pattern_high_r;
    reg [7:0] offset_calibration_r;
    reg [7:0] reference_margin_r;

    // Shift path state.
    reg [`ACS_WORD_W-1:0] output_data_register_r;
    reg [`ACS_WORD_W-1:0] unified_shift_register_r;
    reg [`ACS_WORD_W-1:0] input_data_register_r;
    reg [`ACS_CNT_W-1:0] capture_cnt_r;
    reg [7:0] readback_r;
    reg readback_pend_r;

    // Derived strobes.
    wire cpol;
    wire cpha;
    wire frame_on;
    wire frame_start;
    wire frame_end;
    wire sclk_edge;
    wire lead_edge;
    wire capture_edge;
    wire launch_edge;
    wire conv_rise;
    wire legacy_mode;
    wire [`ACS_WORD_W-1:0] cmd_word;
    wire [3:0] cmd_op;
    wire [7:0] cmd_addr;
    wire [7:0] cmd_data;
    wire cmd_ok;
    reg [7:0] reg_rdata;

    // Two flip-flops on every pin; the third stage only feeds edge detection.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            conv_s1_r <= 1'b0;
            conv_s2_r <= 1'b0;
            conv_s3_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end
        else
        begin
            conv_s1_r <= conv_start_i;
            conv_s2_r <= conv_s1_r;
            conv_s3_r <= conv_s2_r;
            cs_s1_r <= cs_n_i;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            sclk_s1_r <= sclk_i;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            sdi_s1_r <= sdi_i;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    // Clock polarity and phase come from the write protocol field.
    assign cpol = write_protocol_select_r[`ACS_BIT_CPOL];
    assign cpha = write_protocol_select_r[`ACS_BIT_CPHA];

    // Frame boundaries follow chip select.
    assign frame_on = ~cs_s2_r & ~cs_s3_r;
    assign frame_start = ~cs_s2_r & cs_s3_r;
    assign frame_end = cs_s2_r & ~cs_s3_r;

    // A leading edge leaves the idle level; phase picks capture or launch.
    assign sclk_edge = frame_on & (sclk_s2_r ^ sclk_s3_r);
    assign lead_edge = sclk_edge & (sclk_s3_r == cpol);
    assign capture_edge = cpha ? (sclk_edge & ~lead_edge) : lead_edge;
    assign launch_edge = cpha ? lead_edge : (sclk_edge & ~lead_edge);

    assign conv_rise = conv_s2_r & ~conv_s3_r;

    // Legacy read protocols collapse both registers into one.
    assign legacy_mode = (read_protocol_select_r == `ACS_RPROT_LEGACY0) ||
                         (read_protocol_select_r == `ACS_RPROT_LEGACY1);

    // The command is whatever is left in the shifter at chip select rise.
    assign cmd_word = legacy_mode ? unified_shift_register_r : input_data_register_r;
    assign cmd_op = cmd_word[`ACS_CMD_OP_HI:`ACS_CMD_OP_LO];
    assign cmd_addr = cmd_word[`ACS_CMD_ADDR_HI:`ACS_CMD_ADDR_LO];
    assign cmd_data = cmd_word[7:0];
    assign cmd_ok = frame_end && (capture_cnt_r == `ACS_WORD_BITS);

    // Read-back mux; unmapped addresses return zero.
    always @*
    begin
        case (cmd_addr)
            `ACS_OFS_PWR: reg_rdata = power_down_control_r;
            `ACS_OFS_WPROT: reg_rdata = write_protocol_select_r;
            `ACS_OFS_RPROT: reg_rdata = read_protocol_select_r;
            `ACS_OFS_OWORD: reg_rdata = output_word_config_r;
            `ACS_OFS_PAT_LO: reg_rdata = test_pattern_low_r;
            `ACS_OFS_PAT_MID: reg_rdata = test_pattern_mid_r;
            `ACS_OFS_PAT_HI: reg_rdata = test_pattern_high_r;
            `ACS_OFS_OFSCAL: reg_rdata = offset_calibration_r;
            `ACS_OFS_REFMRG: reg_rdata = reference_margin_r;
            default: reg_rdata = 8'h00;
        endcase
    end

    // Register writes land only when a full word ends the frame.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            power_down_control_r <= `ACS_RST_REG;
            write_protocol_select_r <= `ACS_RST_REG;
            read_protocol_select_r <= `ACS_RST_REG;
            output_word_config_r <= `ACS_RST_REG;
            test_pattern_low_r <= `ACS_RST_REG;
            test_pattern_mid_r <= `ACS_RST_REG;
            test_pattern_high_r <= `ACS_RST_REG;
            offset_calibration_r <= `ACS_RST_REG;
            reference_margin_r <= `ACS_RST_REG;
        end
        else if (cmd_ok && (cmd_op == `ACS_OP_WRITE))
        begin
            case (cmd_addr)
                `ACS_OFS_PWR: power_down_control_r <= cmd_data & `ACS_MSK_PWR;
                `ACS_OFS_WPROT: write_protocol_select_r <= cmd_data & `ACS_MSK_WPROT;
                `ACS_OFS_RPROT: read_protocol_select_r <= cmd_data & `ACS_MSK_RPROT;
                `ACS_OFS_OWORD: output_word_config_r <= cmd_data & `ACS_MSK_OWORD;
                `ACS_OFS_PAT_LO: test_pattern_low_r <= cmd_data & `ACS_MSK_FULL;
                `ACS_OFS_PAT_MID: test_pattern_mid_r <= cmd_data & `ACS_MSK_FULL;
                `ACS_OFS_PAT_HI: test_pattern_high_r <= cmd_data & `ACS_MSK_PAT_HI;
                `ACS_OFS_OFSCAL: offset_calibration_r <= cmd_data;
                `ACS_OFS_REFMRG: reference_margin_r <= cmd_data;
                default: power_down_control_r <= power_down_control_r;
            endcase
        end
    end

    // A read command arms the next frame to return the addressed register.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            readback_r <= 8'h00;
            readback_pend_r <= 1'b0;
        end
        else if (cmd_ok)
        begin
            readback_pend_r <= (cmd_op == `ACS_OP_READ);
            readback_r <= reg_rdata;
        end
        else if (frame_start)
        begin
            readback_pend_r <= 1'b0;
        end
    end

    // Conversion results wait in the output data register.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            output_data_register_r <= `ACS_RST_WORD;
        end
        else if (conv_done_i)
        begin
            output_data_register_r <= conv_data_i;
        end
    end

    // Capture counter saturates at all ones (31), past a full word.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            capture_cnt_r <= {`ACS_CNT_W{1'b0}};
        end
        else if (frame_start)
        begin
            capture_cnt_r <= {`ACS_CNT_W{1'b0}};
        end
        else if (capture_edge && (capture_cnt_r != {`ACS_CNT_W{1'b1}}))
        begin
            capture_cnt_r <= capture_cnt_r + 1'b1;
        end
    end

    // Output shifter; in legacy mode it also takes the input bits.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            unified_shift_register_r <= `ACS_RST_WORD;
        end
        else if (frame_start)
        begin
            if (readback_pend_r)
            begin
                unified_shift_register_r <= {14'h0000, readback_r};
            end
            else
            begin
                unified_shift_register_r <= output_data_register_r;
            end
        end
        else if (capture_edge)
        begin
            unified_shift_register_r <= {unified_shift_register_r[`ACS_WORD_W-2:0],
                                         legacy_mode & sdi_s2_r};
        end
    end

    // Separate input register used outside the legacy protocols.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            input_data_register_r <= `ACS_RST_WORD;
        end
        else if (frame_start)
        begin
            input_data_register_r <= `ACS_RST_WORD;
        end
        else if (capture_edge)
        begin
            input_data_register_r <= {input_data_register_r[`ACS_WORD_W-2:0], sdi_s2_r};
        end
    end

    // Data line: MSB is placed at frame start and on every launch edge.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end
        else
        begin
            sdo_oe_o <= ~cs_s2_r;
            if (frame_start)
            begin
                sdo_o <= readback_pend_r ? 1'b0 : output_data_register_r[`ACS_WORD_W-1];
            end
            else if (launch_edge)
            begin
                sdo_o <= unified_shift_register_r[`ACS_WORD_W-1];
            end
        end
    end

    // Sample strobe and status outputs.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sample_o <= 1'b0;
            unified_o <= 1'b1;
            test_pattern_o <= 20'h00000;
        end
        else
        begin
            sample_o <= conv_rise;
            unified_o <= legacy_mode;
            test_pattern_o <= {test_pattern_high_r[3:0], test_pattern_mid_r, test_pattern_low_r};
        end
    end

    // Power controls change only as chip select rises after the write.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            core_off_o <= 1'b0;
            ref_buf_off_o <= 1'b0;
        end
        else if (cmd_ok && (cmd_op == `ACS_OP_WRITE) && (cmd_addr == `ACS_OFS_PWR))
        begin
            core_off_o <= cmd_data[`ACS_BIT_CORE_OFF];
            ref_buf_off_o <= cmd_data[`ACS_BIT_REFBUF_OFF];
        end
    end

endmodule // acs_spi_chain

// *** bench/acs_spi_chain_sva.sv ***
`timescale 1ns/1ps
module acs_spi_chain_sva (
    input wire sys_clk_i, // System clock.
    input wire rst_n_i, // Reset, active low.
    input wire conv_start_i, // Conversion start pin.
    input wire cs_n_i, // Chip select, active low.
    input wire sclk_i, // Serial clock pin.
    input wire sdo_o, // Serial data out.
    input wire sdo_oe_o, // Data line enable.
    input wire sample_o, // Sample pulse.
    input wire core_off_o, // Core powered down.
    input wire ref_buf_off_o, // Buffer powered down.
    input wire unified_o, // Unified shifter in use.
    input wire [19:0] test_pattern_o // Assembled pattern.
);
    default clocking dcb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    reg [3:0] quiet_r;
    reg sclk_q_r;
    reg cs_q_r;
    // Counts cycles since the link pins last moved, so output settling can be judged.
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            quiet_r <= 4'h0;
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b1;
        end
        else
        begin
            sclk_q_r <= sclk_i;
            cs_q_r <= cs_n_i;
            if ((sclk_i != sclk_q_r) || (cs_n_i != cs_q_r))
                quiet_r <= 4'h0;
            else if (quiet_r != 4'hf)
                quiet_r <= quiet_r + 4'h1;
        end
    end
    AST_SAMPLE: assert property ($rose(conv_start_i) |-> ##[2:4] sample_o)
        else $error("no sample pulse after conversion start");
    AST_SAMPLE_ONE: assert property (sample_o |=> !sample_o)
        else $error("sample pulse too long");
    AST_FRAME_START: assert property ($fell(cs_n_i) |-> ##[2:4] sdo_oe_o)
        else $error("frame did not start");
    AST_FRAME_END: assert property ($rose(cs_n_i) |-> ##[2:4] !sdo_oe_o)
        else $error("frame did not end");
    AST_OE_IDLE: assert property (cs_n_i [*4] |-> !sdo_oe_o)
        else $error("data line driven while deselected");
    AST_CORE_AT_CS: assert property ($changed(core_off_o) |-> cs_n_i && $past(cs_n_i))
        else $error("core power changed inside a frame");
    AST_REF_AT_CS: assert property ($changed(ref_buf_off_o) |-> cs_n_i && $past(cs_n_i))
        else $error("buffer power changed inside a frame");
    AST_CFG_AT_CS: assert property ($changed(test_pattern_o) || $changed(unified_o) |-> cs_n_i)
        else $error("configuration changed inside a frame");
    AST_SDO_QUIET: assert property (!cs_n_i && quiet_r >= 4'h6 |-> $stable(sdo_o))
        else $error("data out moved without a clock edge");
endmodule // acs_spi_chain_sva
bind acs_spi_chain acs_spi_chain_sva u_acs_spi_chain_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .conv_start_i(conv_start_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .sample_o(sample_o), .core_off_o(core_off_o), .ref_buf_off_o(ref_buf_off_o), .unified_o(unified_o),
    .test_pattern_o(test_pattern_o));

// *** bench/acs_host_model.sv ***
`timescale 1ns/1ps
module acs_host_model #(
    parameter WAKE_CLK = 8 // Wake-up wait after each frame, in clocks.
) (
    input wire sys_clk_i, // Pacing clock.
    input wire sdo_i, // Data from the device.
    output reg cs_n_o, // Chip select, active low.
    output reg sclk_o, // Serial clock.
    output reg sdi_o // Data to the device.
);
    reg [1:0] mode; // Polarity and phase of the next frames.
    reg [21:0] sh_r;
    integer k;
    // Starts deselected with the clock idle.
    initial
    begin
        mode = 2'b00;
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Waits n clocks and steps just past the edge.
    task hw(input integer n);
    begin
        repeat (n) @(posedge sys_clk_i);
        #1;
    end
    endtask
    // One frame of n capture edges, MSB first; reply bits are taken just before each trailing edge.
    task xfer(input [21:0] w, input integer n, output [21:0] r);
    begin
        r = 22'h000000;
        sh_r = w;
        sclk_o = mode[1];
        hw(4);
        cs_n_o = 1'b0;
        sdi_o = sh_r[21];
        hw(8);
        for (k = 0; k < n; k = k + 1)
        begin
            sclk_o = ~mode[1];
            if (mode[0])
                sdi_o = sh_r[21];
            hw(3);
            r = {r[20:0], sdo_i};
            hw(1);
            sclk_o = mode[1];
            sh_r = sh_r << 1;
            if (!mode[0])
                sdi_o = sh_r[21];
            hw(4);
        end
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // Released line shows no stale bit.
        hw(WAKE_CLK);
    end
    endtask
endmodule // acs_host_model

// *** bench/tb_acs_spi_chain.sv ***
`timescale 1ns/1ps
`include "acs_map.vh"
module tb_acs_spi_chain;
    localparam [71:0] ADRS = {8'h04, 8'h10, 8'h14, 8'h15, 8'h16, 8'h20, 8'h30, 8'h08, 8'h0c};
    localparam [55:0] MSKS = {8'h06, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
    reg sys_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg conv_start_i = 1'b0;
    reg conv_done_i = 1'b0;
    reg [21:0] conv_data_i = 22'h000000;
    wire cs_n, sclk, sdi, sdo_o, sdo_oe_o, sample_o, core_off_o, ref_buf_off_o, unified_o;
    wire [19:0] test_pattern_o;
    wire [21:0] flags = {19'h0, core_off_o, ref_buf_off_o, unified_o};
    // A data line the device does not drive shows the inverse of its last bit to the host.
    wire sdo_line = sdo_oe_o ? sdo_o : ~sdo_o;
    integer fails = 0;
    integer comparisons = 0;
    integer i;
    reg [21:0] r;
    acs_spi_chain u_acs_spi_chain (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sample_o(sample_o), .core_off_o(core_off_o),
        .ref_buf_off_o(ref_buf_off_o), .unified_o(unified_o), .test_pattern_o(test_pattern_o));
    acs_host_model u_acs_host_model (.sys_clk_i(sys_clk_i), .sdo_i(sdo_line), .cs_n_o(cs_n), .sclk_o(sclk),
        .sdi_o(sdi));
    // Free-running 40 MHz clock.
    initial
    begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // Compares one result and reports a mismatch at once.
    task chk(input [21:0] got, input [21:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    end
    endtask
    // Writes one register with a full-length frame.
    task wr(input [7:0] a, input [7:0] v);
    begin
        u_acs_host_model.xfer({`ACS_OP_WRITE, 2'b00, a, v}, 22, r);
    end
    endtask
    // Reads one register; the value returns in the following frame.
    task rdchk(input [7:0] a, input [7:0] exp);
    begin
        u_acs_host_model.xfer({`ACS_OP_READ, 2'b00, a, 8'h00}, 22, r);
        u_acs_host_model.xfer(22'h000000, 22, r);
        chk(r, {14'h0, exp});
    end
    endtask
    // Prints the counts and the verdict, then stops.
    task finish_test;
    begin
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // Cuts a hang short.
    initial
    begin
        repeat (80000) @(posedge sys_clk_i);
        fails = fails + 1;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test;
    end
    // Main sequence of tests.
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        u_acs_host_model.hw(4);
        chk(flags, 22'h1);
        chk({2'b0, test_pattern_o}, 22'h0);
        for (i = 0; i < 9; i = i + 1)
            rdchk(ADRS[8*i +: 8], 8'h00);
        $display("test reset_values done");
        for (i = 2; i < 9; i = i + 1)
        begin
            wr(ADRS[8*i +: 8], 8'hff);
            rdchk(ADRS[8*i +: 8], MSKS[8*(i-2) +: 8]);
        end
        chk(flags, 22'h7);
        wr(`ACS_OFS_PWR, 8'h04);
        chk(flags, 22'h3);
        wr(`ACS_OFS_PWR, 8'h02);
        chk(flags, 22'h5);
        u_acs_host_model.xfer({`ACS_OP_WRITE, 2'b00, `ACS_OFS_PWR, 8'h00}, 21, r);
        chk(flags, 22'h5);
        $display("test power_and_masks done");
        wr(`ACS_OFS_PAT_LO, 8'ha5);
        wr(`ACS_OFS_PAT_MID, 8'h3c);
        wr(`ACS_OFS_PAT_HI, 8'hf9);
        chk({2'b0, test_pattern_o}, 22'h093ca5);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`ACS_OFS_WPROT, 8'hfc | i[7:0]);
            u_acs_host_model.mode = i[1:0];
            wr(`ACS_OFS_PAT_LO, 8'h40 + i[7:0]);
            chk({2'b0, test_pattern_o}, 22'h093c40 + i[21:0]);
        end
        wr(`ACS_OFS_WPROT, 8'hfc);
        u_acs_host_model.mode = 2'b00;
        rdchk(`ACS_OFS_WPROT, 8'h00);
        $display("test clock_modes done");
        wr(`ACS_OFS_RPROT, 8'h02);
        chk(flags, 22'h4);
        wr(`ACS_OFS_RPROT, 8'h01);
        chk(flags, 22'h5);
        rdchk(`ACS_OFS_RPROT, 8'h01);
        wr(`ACS_OFS_RPROT, 8'h00);
        // A double-length frame passes the host word through the unified shifter to the data line.
        u_acs_host_model.xfer(22'h15a3c7, 44, r);
        chk(r, 22'h15a3c7);
        conv_start_i = 1'b1;
        u_acs_host_model.hw(4);
        conv_start_i = 1'b0;
        conv_data_i = 22'h2a5c3e;
        conv_done_i = 1'b1;
        u_acs_host_model.hw(1);
        conv_done_i = 1'b0;
        u_acs_host_model.xfer(22'h000000, 22, r);
        chk(r, 22'h2a5c3e);
        $display("test protocol_and_readout done");
        finish_test;
    end
endmodule // tb_acs_spi_chain
